// ### include/tsa_pkg.sv
package tsa_pkg;

    typedef logic [3:0] tsa_addr_t;
    typedef logic [7:0] tsa_byte_t;
    typedef logic [4:0] tsa_slot_t;
    typedef logic [7:0] tsa_pos_t;

    localparam int NUM_REGS = 4;

    // ************************************************************
    // Host register offsets
    // ************************************************************
    localparam tsa_addr_t ADDR_DATA0 = 4'h0;
    localparam tsa_addr_t ADDR_SEL0  = 4'h4;
    localparam tsa_addr_t ADDR_CTRL0 = 4'h8;
    localparam tsa_addr_t ADDR_STAT  = 4'ha;
    localparam tsa_addr_t ADDR_MASK  = 4'hb;
    localparam tsa_addr_t ADDR_ACK   = 4'hc;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int SEL_LINE_BIT = 7;
    localparam int CTL_IN_EN0   = 0;
    localparam int CTL_OUT_EN0  = 2;
    localparam int CTL_SWAP     = 4;
    localparam int CTL_TBM      = 5;
    localparam int MASK_STOV0   = 4;

    localparam tsa_byte_t SEL_RST  = 8'h00;
    localparam tsa_byte_t CTRL_RST = 8'h00;
    localparam tsa_byte_t MASK_RST = 8'h00;
    localparam tsa_byte_t DATA_RST = 8'hff;

    localparam tsa_slot_t TIC_SLOT     = 5'h0b;
    localparam tsa_slot_t DCH_ODD_SLOT = 5'h03;

    // Bit clocks from slot end to transfer event, per line select
    localparam tsa_pos_t DLY_LINE0 = 8'h02;
    localparam tsa_pos_t DLY_LINE1 = 8'h01;

    // ************************************************************
    // Link timing
    // ************************************************************
    localparam int CORE_PERIOD_NS = 10;
    localparam int DCL_PERIOD_NS  = 125;
    localparam int DCL_HALF_CYC   = DCL_PERIOD_NS / (2 * CORE_PERIOD_NS);
    localparam tsa_pos_t LAST_POS     = 8'hff;
    localparam tsa_pos_t FSC_LOW_POS  = 8'h08;

    function automatic tsa_pos_t line_dly(input logic line);
        return line ? DLY_LINE1 : DLY_LINE0;
    endfunction

    function automatic tsa_pos_t sti_pos(input tsa_slot_t s,
                                         input logic line);
        return {s, 3'b111} + line_dly(line);
    endfunction

    function automatic tsa_pos_t chk_pos(input tsa_slot_t s,
                                         input logic line);
        return {s, 3'b000} - line_dly(line);
    endfunction

endpackage

// ### include/tsa_if.sv
interface tsa_if;
    logic dcl;
    logic fsc;
    logic dev_du_o;
    logic dev_du_oe;
    logic dev_dd_o;
    logic dev_dd_oe;
    logic far_du_o;
    logic far_du_oe;
    logic du;
    logic dd;

    // Idle lines float high; any driven low wins
    assign du = (dev_du_oe ? dev_du_o : 1'b1) & (far_du_oe ? far_du_o : 1'b1);
    assign dd = dev_dd_oe ? dev_dd_o : 1'b1;

    modport dev (input dcl, fsc, du, dd,
                 output dev_du_o, dev_du_oe, dev_dd_o, dev_dd_oe);
    modport far (output dcl, fsc, far_du_o, far_du_oe,
                 input du, dd);
endinterface

// ### rtl/tsa_dev.sv
// Implementation choices: the register offsets and the strobed register port.
module tsa_dev (
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               ce,
    input  wire tsa_pkg::tsa_addr_t addr,
    input  wire tsa_pkg::tsa_byte_t wdata,
    input  wire logic               wr,
    input  wire logic               rd,
    output tsa_pkg::tsa_byte_t      rdata,
    tsa_if.dev                      link
);
    import tsa_pkg::*;

    typedef enum logic [1:0] {ST_HUNT, ST_ARMED, ST_RUN} tsa_state_t;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [1:0] dcl_s_ff;
    logic [1:0] fsc_s_ff;
    logic [1:0] du_s_ff;
    logic [1:0] dd_s_ff;
    logic       dcl_d_ff;
    logic       fsc_d_ff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dcl_s_ff <= 2'h0;
            fsc_s_ff <= 2'h0;
            du_s_ff  <= 2'h3;
            dd_s_ff  <= 2'h3;
            dcl_d_ff <= 1'b0;
            fsc_d_ff <= 1'b0;
        end else if (ce) begin
            dcl_s_ff <= {dcl_s_ff[0], link.dcl};
            fsc_s_ff <= {fsc_s_ff[0], link.fsc};
            du_s_ff  <= {du_s_ff[0], link.du};
            dd_s_ff  <= {dd_s_ff[0], link.dd};
            dcl_d_ff <= dcl_s_ff[1];
            fsc_d_ff <= fsc_s_ff[1];
        end
    end

    logic dcl_rise;
    logic dcl_fall;
    logic fsc_rise;
    assign dcl_rise = dcl_s_ff[1] & ~dcl_d_ff;
    assign dcl_fall = ~dcl_s_ff[1] & dcl_d_ff;
    assign fsc_rise = fsc_s_ff[1] & ~fsc_d_ff;

    // ************************************************************
    // Frame position
    // ************************************************************
    tsa_state_t state_ff;
    tsa_pos_t   pos_ff;
    logic       phase_ff;
    logic       launch;
    logic       sample;
    tsa_pos_t   lpos;

    assign launch = dcl_rise & ((state_ff == ST_ARMED) |
                                ((state_ff == ST_RUN) & phase_ff));
    assign sample = dcl_fall & (state_ff == ST_RUN) & phase_ff;
    assign lpos   = (state_ff == ST_ARMED) ? 8'h00 : pos_ff + 8'h01;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= ST_HUNT;
            pos_ff   <= 8'h00;
            phase_ff <= 1'b0;
        end else if (ce) begin
            if (fsc_rise) begin
                state_ff <= ST_ARMED;
            end else if (launch) begin
                state_ff <= ST_RUN;
                pos_ff   <= lpos;
                phase_ff <= 1'b0;
            end else if (dcl_rise && state_ff == ST_RUN) begin
                phase_ff <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Host registers
    // ************************************************************
    tsa_byte_t data_ff [NUM_REGS];
    tsa_byte_t sel_ff  [NUM_REGS];
    tsa_byte_t ctrl_ff [2];
    tsa_byte_t osh_ff  [NUM_REGS];
    tsa_byte_t cap_ff  [NUM_REGS];
    tsa_byte_t mask_ff;
    logic [3:0] pend_ff;
    logic [3:0] transfer_overflow_interrupt_ff;
    tsa_byte_t  rdata_ff;

    // ************************************************************
    // Slot matching per register
    // ************************************************************
    logic [3:0] in_en;
    logic [3:0] in_line;
    logic [3:0] cap_hit;
    logic [3:0] commit;
    logic [3:0] sti_ev;
    logic [3:0] chk_ev;
    logic [3:0] drv;
    logic [3:0] drv_bit;
    logic [3:0] transfer_overflow_interrupt_set;
    logic [3:0] ack_w;
    logic [3:0] transfer_interrupt_mask;
    logic [3:0] mstov;
    tsa_byte_t  cur_byte [NUM_REGS];

    assign transfer_interrupt_mask  = mask_ff[3:0];
    assign mstov = mask_ff[MASK_STOV0 +: 4];
    assign ack_w = (ce && wr && addr == ADDR_ACK) ? wdata[3:0] : 4'h0;

    always_comb begin
        tsa_byte_t isel;
        tsa_slot_t islot;
        logic      oline;
        isel  = 8'h00;
        islot = 5'h00;
        oline = 1'b0;
        for (int i = 0; i < NUM_REGS; i++) begin
            // Input select follows partner when exchanged
            isel = ctrl_ff[i / 2][CTL_SWAP] ? sel_ff[i ^ 1]
                                            : sel_ff[i];
            islot = isel[4:0];
            if (ctrl_ff[i / 2][CTL_TBM]) begin
                islot = (i % 2 == 0) ? TIC_SLOT : DCH_ODD_SLOT;
            end
            in_line[i] = isel[SEL_LINE_BIT];
            in_en[i]   = ctrl_ff[i / 2][CTL_IN_EN0 + i % 2];
            cap_hit[i] = sample & in_en[i] & (pos_ff[7:3] == islot);
            // Commit late so a neighbouring output slot sees old data
            commit[i]  = launch & in_en[i] &
                         (lpos == sti_pos(islot, in_line[i]));
            oline      = sel_ff[i][SEL_LINE_BIT];
            sti_ev[i]  = launch &
                         (lpos == sti_pos(sel_ff[i][4:0], oline));
            chk_ev[i]  = launch &
                         (lpos == chk_pos(sel_ff[i][4:0], oline));
            drv[i]     = launch & ctrl_ff[i / 2][CTL_OUT_EN0 + i % 2] &
                         (lpos[7:3] == sel_ff[i][4:0]);
            cur_byte[i] = (lpos[2:0] == 3'h0) ? data_ff[i] : osh_ff[i];
            drv_bit[i]  = cur_byte[i][3'h7 - lpos[2:0]];
        end
    end

    // Overflow: own pending event, or any other when own is masked
    always_comb begin
        for (int k = 0; k < NUM_REGS; k++) begin
            transfer_overflow_interrupt_set[k] = 1'b0;
            for (int i = 0; i < NUM_REGS; i++) begin
                if (chk_ev[i] && pend_ff[i] && transfer_interrupt_mask[i] &&
                    (i == k || !transfer_interrupt_mask[k])) begin
                    transfer_overflow_interrupt_set[k] = mstov[k];
                end
            end
        end
    end

    // ************************************************************
    // Data path
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                data_ff[i] <= DATA_RST;
                osh_ff[i]  <= DATA_RST;
                cap_ff[i]  <= DATA_RST;
            end
        end else if (ce) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                if (cap_hit[i]) begin
                    cap_ff[i] <= {cap_ff[i][6:0],
                                  in_line[i] ? dd_s_ff[1] : du_s_ff[1]};
                end
                // Link commit wins over a colliding host write
                if (commit[i]) begin
                    data_ff[i] <= cap_ff[i];
                end else if (wr && addr == ADDR_DATA0 + 4'(i)) begin
                    data_ff[i] <= wdata;
                end
                if (drv[i]) begin
                    osh_ff[i] <= cur_byte[i];
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                sel_ff[i] <= SEL_RST;
            end
            ctrl_ff[0] <= CTRL_RST;
            ctrl_ff[1] <= CTRL_RST;
            mask_ff    <= MASK_RST;
        end else if (ce && wr) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                if (addr == ADDR_SEL0 + 4'(i)) begin
                    sel_ff[i] <= wdata;
                end
            end
            for (int p = 0; p < 2; p++) begin
                if (addr == ADDR_CTRL0 + 4'(p)) begin
                    ctrl_ff[p] <= wdata;
                end
            end
            if (addr == ADDR_MASK) begin
                mask_ff <= wdata;
            end
        end
    end

    // ************************************************************
    // Transfer status, set wins over clear
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pend_ff <= 4'h0;
            transfer_overflow_interrupt_ff <= 4'h0;
        end else if (ce) begin
            pend_ff <= (pend_ff & ~ack_w) | (sti_ev & transfer_interrupt_mask);
            transfer_overflow_interrupt_ff <= (transfer_overflow_interrupt_ff & ~((rd && addr == ADDR_STAT) ? 4'hf : 4'h0))
                       | transfer_overflow_interrupt_set;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (ce) begin
            rdata_ff <= 8'h00;
            if (rd) begin
                unique case (addr)
                    ADDR_STAT: rdata_ff <= {transfer_overflow_interrupt_ff, pend_ff};
                    ADDR_MASK: rdata_ff <= mask_ff;
                    4'h0, 4'h1, 4'h2, 4'h3: rdata_ff <= data_ff[addr[1:0]];
                    4'h4, 4'h5, 4'h6, 4'h7: rdata_ff <= sel_ff[addr[1:0]];
                    4'h8, 4'h9: rdata_ff <= ctrl_ff[addr[0]];
                    default: rdata_ff <= 8'h00;
                endcase
            end
        end
    end
    assign rdata = rdata_ff;

    // ************************************************************
    // Line drivers
    // ************************************************************
    logic du_o_ff;
    logic du_oe_ff;
    logic dd_o_ff;
    logic dd_oe_ff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            du_o_ff  <= 1'b1;
            du_oe_ff <= 1'b0;
            dd_o_ff  <= 1'b1;
            dd_oe_ff <= 1'b0;
        end else if (ce && launch) begin
            du_o_ff  <= &(drv_bit | ~(drv & sel_line_vec(1'b1)));
            du_oe_ff <= |(drv & sel_line_vec(1'b1));
            dd_o_ff  <= &(drv_bit | ~(drv & sel_line_vec(1'b0)));
            dd_oe_ff <= |(drv & sel_line_vec(1'b0));
        end else if (ce && state_ff == ST_HUNT) begin
            du_oe_ff <= 1'b0;
            dd_oe_ff <= 1'b0;
        end
    end

    // Registers whose output goes to the given line
    function automatic logic [3:0] sel_line_vec(input logic line);
        logic [3:0] v;
        for (int i = 0; i < NUM_REGS; i++) begin
            v[i] = (sel_ff[i][SEL_LINE_BIT] == line);
        end
        return v;
    endfunction

    assign link.dev_du_o  = du_o_ff;
    assign link.dev_du_oe = du_oe_ff;
    assign link.dev_dd_o  = dd_o_ff;
    assign link.dev_dd_oe = dd_oe_ff;

endmodule // tsa_dev

// ### rtl/tsa_far.sv
module tsa_far (
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               ce,
    input  wire logic               tx_en,
    input  wire tsa_pkg::tsa_slot_t tx_slot,
    input  wire tsa_pkg::tsa_byte_t tx_byte,
    input  wire tsa_pkg::tsa_slot_t rx_slot,
    output tsa_pkg::tsa_byte_t      rx_byte,
    output logic                    rx_valid,
    output logic                    frame_start,
    tsa_if.far                      link
);
    import tsa_pkg::*;

    // ************************************************************
    // Clock divider and frame position
    // ************************************************************
    logic [7:0] div_ff;
    logic       dcl_ff;
    logic       phase_ff;
    tsa_pos_t   pos_ff;
    logic       fsc_ff;
    logic       tick;
    tsa_pos_t   npos;

    assign tick = (div_ff == 8'(DCL_HALF_CYC - 1));
    assign npos = pos_ff + 8'h01;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_ff <= 8'h00;
            dcl_ff <= 1'b0;
        end else if (ce) begin
            div_ff <= tick ? 8'h00 : div_ff + 8'h01;
            if (tick) begin
                dcl_ff <= ~dcl_ff;
            end
        end
    end

    // Sync rises on the last falling edge, so the next rise is bit 0
    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_ff <= 1'b0;
            pos_ff   <= LAST_POS;
            fsc_ff   <= 1'b0;
        end else if (ce && tick) begin
            if (!dcl_ff) begin
                phase_ff <= ~phase_ff;
                if (phase_ff) begin
                    pos_ff <= npos;
                    if (npos == FSC_LOW_POS) begin
                        fsc_ff <= 1'b0;
                    end
                end
            end else if (phase_ff && pos_ff == LAST_POS) begin
                fsc_ff <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Upstream driver and downstream receiver
    // ************************************************************
    logic      du_o_ff;
    logic      du_oe_ff;
    logic      fs_ff;
    tsa_byte_t sh_ff;
    tsa_byte_t rx_ff;
    logic      rxv_ff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            du_o_ff  <= 1'b1;
            du_oe_ff <= 1'b0;
            fs_ff    <= 1'b0;
        end else if (ce) begin
            fs_ff <= 1'b0;
            if (tick && !dcl_ff && phase_ff) begin
                du_oe_ff <= tx_en && npos[7:3] == tx_slot;
                du_o_ff  <= tx_byte[3'h7 - npos[2:0]];
                fs_ff    <= (npos == 8'h00);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sh_ff  <= 8'h00;
            rx_ff  <= 8'h00;
            rxv_ff <= 1'b0;
        end else if (ce) begin
            rxv_ff <= 1'b0;
            if (tick && dcl_ff && phase_ff && pos_ff[7:3] == rx_slot) begin
                sh_ff <= {sh_ff[6:0], link.dd};
                if (pos_ff[2:0] == 3'h7) begin
                    rx_ff  <= {sh_ff[6:0], link.dd};
                    rxv_ff <= 1'b1;
                end
            end
        end
    end

    assign link.dcl       = dcl_ff;
    assign link.fsc       = fsc_ff;
    assign link.far_du_o  = du_o_ff;
    assign link.far_du_oe = du_oe_ff;
    assign rx_byte        = rx_ff;
    assign rx_valid       = rxv_ff;
    assign frame_start    = fs_ff;

endmodule // tsa_far

// ### tb/tsa_link_monitor.sv
module tsa_link_monitor (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic dcl,
    input wire logic fsc,
    input wire logic dev_dd_o,
    input wire logic dev_dd_oe,
    input wire logic dev_du_oe,
    input wire logic far_du_o,
    input wire logic far_du_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********
    // Helpers
    // ********
    logic       synced_ff;
    logic [7:0] on_cnt_ff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            synced_ff <= 1'b0;
        end else if (fsc) begin
            synced_ff <= 1'b1;
        end
    end

    // Saturates so back-to-back slots cannot wrap it
    always_ff @(posedge core_clk) begin
        if (rst || !dev_dd_oe) begin
            on_cnt_ff <= 8'h00;
        end else if (on_cnt_ff != 8'hff) begin
            on_cnt_ff <= on_cnt_ff + 8'h01;
        end
    end

    // ********
    // Checks
    // ********
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_dd_hold;
        $stable(dev_dd_o)[*8];
    endsequence

    sequence s_fsc_open;
        !dcl ##1 fsc[*8];
    endsequence

    property p_dd_launch;
        ($changed(dev_dd_o) && dev_dd_oe) |-> dcl;
    endproperty
    property p_dd_hold;
        ($changed(dev_dd_o) && dev_dd_oe) |=> s_dd_hold;
    endproperty
    property p_dd_sample;
        ($fell(dcl) && dev_dd_oe) |-> $stable(dev_dd_o);
    endproperty
    property p_quiet;
        !synced_ff |-> (!dev_dd_oe && !dev_du_oe);
    endproperty
    property p_slot_len;
        $fell(dev_dd_oe) |-> (on_cnt_ff >= 8'hb8);
    endproperty
    property p_fsc_open;
        $rose(fsc) |-> s_fsc_open;
    endproperty
    property p_far_launch;
        ($changed(far_du_o) && far_du_oe) |-> dcl;
    endproperty
    property p_no_clash;
        !(far_du_oe && dev_du_oe);
    endproperty

    a_dd_launch: assert property (p_dd_launch)
        else $error("dd bit launched while dcl low");
    a_dd_hold: assert property (p_dd_hold)
        else $error("dd bit did not hold");
    a_dd_sample: assert property (p_dd_sample)
        else $error("dd changed at sampling edge");
    a_quiet: assert property (p_quiet)
        else $error("link driven before frame sync");
    a_slot_len: assert property (p_slot_len)
        else $error("dd driven for less than a slot");
    a_fsc_open: assert property (p_fsc_open)
        else $error("frame sync shape wrong");
    a_far_launch: assert property (p_far_launch)
        else $error("du bit launched while dcl low");
    a_no_clash: assert property (p_no_clash)
        else $error("both ends drive du");

endmodule // tsa_link_monitor

// ### tb/test_tdm_slot_access_unit.sv
module test_tdm_slot_access_unit;
    timeunit 1ns;
    timeprecision 1ps;
    import tsa_pkg::*;

    logic      core_clk, rst, ce, wr, rd, tx_en, rx_valid, frame_start;
    tsa_addr_t addr;
    tsa_byte_t wdata, rdata, tx_byte, rx_byte, rd_val;
    tsa_slot_t tx_slot, rx_slot;
    int        error_cnt = 0;
    int        samples_checked = 0;

    tsa_if bus ();

    tsa_dev i_tsa_dev (.core_clk(core_clk), .rst(rst), .ce(ce),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .link(bus));

    tsa_far i_tsa_far (.core_clk(core_clk), .rst(rst), .ce(ce),
        .tx_en(tx_en), .tx_slot(tx_slot), .tx_byte(tx_byte),
        .rx_slot(rx_slot), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .frame_start(frame_start), .link(bus));

    tsa_link_monitor i_tsa_link_monitor (.core_clk(core_clk),
        .rst(rst), .dcl(bus.dcl), .fsc(bus.fsc),
        .dev_dd_o(bus.dev_dd_o), .dev_dd_oe(bus.dev_dd_oe),
        .dev_du_oe(bus.dev_du_oe), .far_du_o(bus.far_du_o),
        .far_du_oe(bus.far_du_oe));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ********
    // Helpers
    // ********
    task automatic reg_wr(input tsa_addr_t a, input tsa_byte_t d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input tsa_addr_t a);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 rd_val = rdata;
    endtask

    task automatic check(input tsa_byte_t got, input tsa_byte_t exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Bounded wait for a far-end pulse: frame start or byte seen
    task automatic wait_ev(input logic use_rx);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while ((use_rx ? rx_valid : frame_start) !== 1'b1
                   && n < 70000);
        if (n >= 70000) begin
            error_cnt++;
            $display("MISMATCH %0t: no link event", $time);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_regs();
        reg_rd(ADDR_SEL0);
        check(rd_val, SEL_RST);
        @(posedge core_clk);
        #1 check(rdata, 8'h00);
        reg_rd(ADDR_CTRL0);
        check(rd_val, CTRL_RST);
        reg_rd(ADDR_MASK);
        check(rd_val, MASK_RST);
        reg_rd(ADDR_DATA0);
        check(rd_val, DATA_RST);
        reg_wr(4'hf, 8'h5a);
        reg_rd(4'hf);
        check(rd_val, 8'h00);
        reg_wr(ADDR_SEL0 + 4'h2, 8'h9f);
        reg_rd(ADDR_SEL0 + 4'h2);
        check(rd_val, 8'h9f);
    endtask

    // Exchanged inputs move slot 2 to slot 6 within one frame
    task automatic t_shift();
        reg_wr(ADDR_SEL0, 8'h02);
        reg_wr(ADDR_SEL0 + 4'h1, 8'h06);
        reg_wr(ADDR_CTRL0, 8'h1b);
        reg_wr(ADDR_MASK, 8'h03);
        tx_en <= 1'b1;
        wait_ev(1'b0);
        tx_byte <= 8'h3c;
        // Frame 0 already left both transfer flags pending
        reg_wr(ADDR_ACK, 8'h03);
        wait_ev(1'b1);
        check(rx_byte, 8'h3c);
        reg_rd(ADDR_STAT);
        check(rd_val & 8'h03, 8'h01);
        repeat (60) @(posedge core_clk);
        reg_rd(ADDR_STAT);
        check(rd_val & 8'h03, 8'h03);
        reg_wr(ADDR_ACK, 8'h03);
        reg_rd(ADDR_STAT);
        check(rd_val & 8'h03, 8'h00);
    endtask

    // Slot 2 looped to the other line, left unacknowledged once
    task automatic t_loop();
        wait_ev(1'b0);
        rx_slot <= 5'h02;
        tx_byte <= 8'h5a;
        reg_wr(ADDR_CTRL0, 8'h05);
        reg_wr(ADDR_MASK, 8'h11);
        wait_ev(1'b1);
        check(rx_byte, 8'hff);
        wait_ev(1'b0);
        tx_byte <= 8'h11;
        reg_wr(ADDR_CTRL0, 8'h04);
        wait_ev(1'b1);
        check(rx_byte, 8'h5a);
        repeat (60) @(posedge core_clk);
        reg_rd(ADDR_STAT);
        check(rd_val & 8'h11, 8'h11);
        reg_rd(ADDR_STAT);
        check(rd_val & 8'h10, 8'h00);
        reg_wr(ADDR_ACK, 8'h01);
        reg_rd(ADDR_STAT);
        check(rd_val & 8'h01, 8'h00);
    endtask

    // Input disabled: stored byte keeps going out
    task automatic t_hold();
        wait_ev(1'b0);
        wait_ev(1'b1);
        check(rx_byte, 8'h5a);
        repeat (60) @(posedge core_clk);
        reg_rd(ADDR_STAT);
        check(rd_val & 8'h10, 8'h00);
    endtask

    // TIC monitor: first register takes slot 11, not its own slot 8
    task automatic t_tic();
        wait_ev(1'b0);
        tx_slot <= TIC_SLOT;
        tx_byte <= 8'hc3;
        reg_wr(ADDR_SEL0, 8'h08);
        reg_wr(ADDR_CTRL0, 8'h21);
        wait_ev(1'b0);
        reg_rd(ADDR_DATA0);
        check(rd_val, 8'hc3);
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        tx_en = 1'b0;
        tx_slot = 5'h02;
        tx_byte = 8'h00;
        rx_slot = 5'h06;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_shift();
        t_loop();
        t_hold();
        t_tic();
        complete_run();
    end

    // About six frames of traffic, with ample margin
    initial begin
        #950000;
        error_cnt++;
        $display("MISMATCH %0t: watchdog", $time);
        complete_run();
    end

endmodule // test_tdm_slot_access_unit
